/* File: rtl/frd_forward_decoder.sv */
// frd_forward_decoder: decides whether an isa master or dma memory cycle goes to pci.
// assumes: config port and isa requests are synchronous to the pci clock clk_i.
// Notes on behaviour
// - forward 1 MB up to top of memory, except inside an enabled hole
// - always forward addresses at or above 16 MB
// - top-of-memory code n in bits 7:4 means (n+1) MB
// - low bios enable bit 3 forwards the E0000-EFFFF window
// - lower bios chip-select enable overrides the low bios forward
// - video enable bit 2 forwards A0000-BFFFF
// - bit 1 forwards 80000-9FFFF
// - bit 0 forwards 0-7FFFF and comes out of reset set
// - add-on bit n forwards the 16 KB block at 768+16n KB
// - hole start register compares with address bits 23:16
// - hole enable bit 7 blocks forwarding inside the hole; resets clear
// - hole size is a thermometer code, 64 KB doubling up to 8 MB
`timescale 1ns/1ps
module frd_forward_decoder (
	// clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// configuration space access
	input wire logic cfg_wr_i,
	input wire logic cfg_rd_i,
	input wire logic [7:0] cfg_idx_i,
	input wire logic [7:0] cfg_wdata_i,
	output logic [7:0] cfg_rdata_o,
	output logic cfg_rvalid_o,
	// chip-select control bit
	input wire logic lower_bios_select_enable_i,
	// isa memory cycle
	input wire logic mem_req_i,
	input wire logic [frd_pkg::ADDR_W-1:0] mem_addr_i,
	// decision
	output logic dec_valid_o,
	output logic forward_o,
	output logic keep_isa_o
);
	logic [1:0] rst_sync_r;
	logic rst_n;
	frd_pkg::frd_state_t s_r;
	frd_pkg::frd_state_t s_nxt;
	logic above_16m;
	logic [3:0] addr_mb;
	logic [3:0] top_of_main_memory;
	logic in_main;
	logic below_1m;
	logic low_hit;
	logic hole_enable;
	logic hole_match;
	logic hole_hit;
	logic fwd_hit;

	// reset released through two flops so every s_r flop leaves reset together
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rst_sync_r <= 2'h0;
		end else begin
			rst_sync_r <= {rst_sync_r[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_r[1];

	frd_hole_match u_hole (
		.addr_hi_i(mem_addr_i[23:16]),
		.hole_start_address_i(s_r.hole_start),
		.hole_size_code_i(s_r.hole_size[frd_pkg::HOLE_SIZE_MSB:0]),
		.match_o(hole_match)
	);

	frd_low_region u_low (
		.addr_i(mem_addr_i[frd_pkg::LOW_W-1:0]),
		.decode_ctrl_i(s_r.decode_ctrl),
		.addon_bios_i(s_r.addon_bios),
		.lower_bios_select_enable_i(lower_bios_select_enable_i),
		.hit_o(low_hit)
	);

	always_comb begin
		above_16m = |mem_addr_i[frd_pkg::ADDR_W-1:24];
		addr_mb = mem_addr_i[frd_pkg::MB_MSB:frd_pkg::MB_LSB];
		top_of_main_memory = s_r.decode_ctrl[frd_pkg::TOM_MSB:frd_pkg::TOM_LSB];
		below_1m = !above_16m && addr_mb == 4'h0;
		// megabyte m is below top when m <= n, top being (n+1) MB
		in_main = !above_16m && addr_mb != 4'h0 && addr_mb <= top_of_main_memory;
		hole_enable = s_r.hole_size[frd_pkg::HOLE_EN_BIT];
		hole_hit = hole_enable && hole_match;
		// hole compare sees only bits 23:16, so it must not veto above 16 MB
		fwd_hit = above_16m || ((in_main || (below_1m && low_hit)) && !hole_hit);
	end

	always_comb begin
		s_nxt = s_r;
		s_nxt.rvalid = cfg_rd_i;
		s_nxt.rdata = frd_pkg::RDATA_NONE;
		// read returns the value before a write in the same cycle
		if (cfg_rd_i) begin
			case (cfg_idx_i)
				frd_pkg::IDX_DECODE_CTRL: begin
					s_nxt.rdata = s_r.decode_ctrl;
				end
				frd_pkg::IDX_ADDON_BIOS: begin
					s_nxt.rdata = s_r.addon_bios;
				end
				frd_pkg::IDX_HOLE_START: begin
					s_nxt.rdata = s_r.hole_start;
				end
				frd_pkg::IDX_HOLE_SIZE: begin
					s_nxt.rdata = s_r.hole_size;
				end
				default: begin
					s_nxt.rdata = frd_pkg::RDATA_NONE;
				end
			endcase
		end
		// reserved size patterns are stored as written; decode stays masked
		if (cfg_wr_i) begin
			case (cfg_idx_i)
				frd_pkg::IDX_DECODE_CTRL: begin
					s_nxt.decode_ctrl = cfg_wdata_i;
				end
				frd_pkg::IDX_ADDON_BIOS: begin
					s_nxt.addon_bios = cfg_wdata_i;
				end
				frd_pkg::IDX_HOLE_START: begin
					s_nxt.hole_start = cfg_wdata_i;
				end
				frd_pkg::IDX_HOLE_SIZE: begin
					s_nxt.hole_size = cfg_wdata_i;
				end
				default: begin
					s_nxt.hole_size = s_r.hole_size;
				end
			endcase
		end
		s_nxt.dvalid = mem_req_i;
		s_nxt.fwd = mem_req_i && fwd_hit;
		s_nxt.keep = mem_req_i && !fwd_hit;
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			s_r.decode_ctrl <= frd_pkg::DECODE_CTRL_RST;
			s_r.addon_bios <= frd_pkg::ADDON_BIOS_RST;
			s_r.hole_start <= frd_pkg::HOLE_START_RST;
			s_r.hole_size <= frd_pkg::HOLE_SIZE_RST;
			s_r.rdata <= frd_pkg::RDATA_NONE;
			s_r.rvalid <= 1'b0;
			s_r.dvalid <= 1'b0;
			s_r.fwd <= 1'b0;
			s_r.keep <= 1'b0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign cfg_rdata_o = s_r.rdata;
	assign cfg_rvalid_o = s_r.rvalid;
	assign dec_valid_o = s_r.dvalid;
	assign forward_o = s_r.fwd;
	assign keep_isa_o = s_r.keep;

	property p_above_16m;
		@(posedge clk_i) disable iff (!rst_n)
		mem_req_i && above_16m |=> dec_valid_o && forward_o && !keep_isa_o;
	endproperty
	a_above_16m: assert property (p_above_16m) else $error("access above 16 MB not forwarded");

	property p_main_memory;
		@(posedge clk_i) disable iff (!rst_n)
		mem_req_i && !above_16m && addr_mb != 4'h0 && addr_mb <= top_of_main_memory
			&& !hole_hit |=> forward_o;
	endproperty
	a_main_memory: assert property (p_main_memory) else $error("main memory not forwarded");

	property p_over_top;
		@(posedge clk_i) disable iff (!rst_n)
		mem_req_i && !above_16m && addr_mb > top_of_main_memory |=> keep_isa_o && !forward_o;
	endproperty
	a_over_top: assert property (p_over_top) else $error("access above top of memory forwarded");

	property p_low_bios_override;
		@(posedge clk_i) disable iff (!rst_n)
		mem_req_i && below_1m && mem_addr_i[19:16] == 4'hE && lower_bios_select_enable_i
			|=> keep_isa_o;
	endproperty
	a_low_bios_override: assert property (p_low_bios_override) else $error("bios select lost");

	property p_low_bios;
		@(posedge clk_i) disable iff (!rst_n)
		mem_req_i && below_1m && mem_addr_i[19:16] == 4'hE && !lower_bios_select_enable_i
			&& s_r.decode_ctrl[frd_pkg::LOW_BIOS_BIT] && !hole_hit |=> forward_o;
	endproperty
	a_low_bios: assert property (p_low_bios) else $error("low bios window not forwarded");

	property p_video;
		@(posedge clk_i) disable iff (!rst_n)
		mem_req_i && below_1m && mem_addr_i[19:17] == frd_pkg::SEG_VIDEO && !hole_hit
			|=> forward_o == $past(s_r.decode_ctrl[frd_pkg::VIDEO_BIT]);
	endproperty
	a_video: assert property (p_video) else $error("video window decision wrong");

	property p_block_640k;
		@(posedge clk_i) disable iff (!rst_n)
		mem_req_i && below_1m && mem_addr_i[19:17] == frd_pkg::SEG_512K && !hole_hit
			|=> forward_o == $past(s_r.decode_ctrl[frd_pkg::B640_BIT]);
	endproperty
	a_block_640k: assert property (p_block_640k) else $error("512-640 KB decision wrong");

	property p_reset_value;
		@(posedge clk_i) disable iff (!rst_n)
		$rose(rst_n) |-> s_r.decode_ctrl == frd_pkg::DECODE_CTRL_RST
			&& !s_r.hole_size[frd_pkg::HOLE_EN_BIT];
	endproperty
	a_reset_value: assert property (p_reset_value) else $error("wrong value after reset");

	property p_addon;
		@(posedge clk_i) disable iff (!rst_n)
		mem_req_i && below_1m && mem_addr_i[19:17] == frd_pkg::SEG_ADDON && !hole_hit
			|=> forward_o == $past(s_r.addon_bios[mem_addr_i[16:14]]);
	endproperty
	a_addon: assert property (p_addon) else $error("add-on block decision wrong");

	property p_hole_blocks;
		@(posedge clk_i) disable iff (!rst_n)
		mem_req_i && !above_16m && hole_enable
			&& ((mem_addr_i[23:16] ^ s_r.hole_start) & ~{1'b0, s_r.hole_size[6:0]}) == 8'h00
			|=> keep_isa_o && !forward_o;
	endproperty
	a_hole_blocks: assert property (p_hole_blocks) else $error("hole access forwarded");

	property p_one_answer;
		@(posedge clk_i) disable iff (!rst_n)
		mem_req_i |=> dec_valid_o && (forward_o != keep_isa_o);
	endproperty
	a_one_answer: assert property (p_one_answer) else $error("not exactly one answer");

	property p_quiet;
		@(posedge clk_i) disable iff (!rst_n)
		!mem_req_i |=> !dec_valid_o && !forward_o && !keep_isa_o;
	endproperty
	a_quiet: assert property (p_quiet) else $error("decision without request");

	property p_hole_write;
		@(posedge clk_i) disable iff (!rst_n)
		cfg_wr_i && cfg_idx_i == frd_pkg::IDX_HOLE_SIZE
			|=> hole_enable == $past(cfg_wdata_i[frd_pkg::HOLE_EN_BIT]);
	endproperty
	a_hole_write: assert property (p_hole_write) else $error("hole enable not stored");

	property p_block_512k;
		@(posedge clk_i) disable iff (!rst_n)
		mem_req_i && below_1m && !mem_addr_i[19] && !hole_hit
			|=> forward_o == $past(s_r.decode_ctrl[frd_pkg::B512_BIT]);
	endproperty
	a_block_512k: assert property (p_block_512k) else $error("0-512 KB decision wrong");

	// the exact start byte is inside the hole whatever the size
	property p_hole_start;
		@(posedge clk_i) disable iff (!rst_n)
		mem_req_i && !above_16m && hole_enable && mem_addr_i[23:16] == s_r.hole_start
			|=> keep_isa_o && !forward_o;
	endproperty
	a_hole_start: assert property (p_hole_start) else $error("hole start missed");

	property p_hole_open;
		@(posedge clk_i) disable iff (!rst_n)
		mem_req_i && !hole_enable && !above_16m && addr_mb != 4'h0
			&& addr_mb <= top_of_main_memory |=> forward_o;
	endproperty
	a_hole_open: assert property (p_hole_open) else $error("disabled hole still blocks");

	property p_hole_8m;
		@(posedge clk_i) disable iff (!rst_n)
		mem_req_i && !above_16m && hole_enable && mem_addr_i[23] == s_r.hole_start[7]
			&& s_r.hole_size[frd_pkg::HOLE_SIZE_MSB:0] == 7'h7F |=> keep_isa_o;
	endproperty
	a_hole_8m: assert property (p_hole_8m) else $error("8 MB hole too small");

	property p_hole_64k;
		@(posedge clk_i) disable iff (!rst_n)
		mem_req_i && hole_enable && s_r.hole_size[frd_pkg::HOLE_SIZE_MSB:0] == 7'h00
			&& mem_addr_i[23:16] != s_r.hole_start && in_main |=> forward_o;
	endproperty
	a_hole_64k: assert property (p_hole_64k) else $error("64 KB hole too large");

	property p_rom_top;
		@(posedge clk_i) disable iff (!rst_n)
		mem_req_i && below_1m && mem_addr_i[19:16] == 4'hF |=> keep_isa_o && !forward_o;
	endproperty
	a_rom_top: assert property (p_rom_top) else $error("boot rom window forwarded");

	property p_read_start;
		@(posedge clk_i) disable iff (!rst_n)
		cfg_rd_i && cfg_idx_i == frd_pkg::IDX_HOLE_START
			|=> cfg_rvalid_o && cfg_rdata_o == $past(s_r.hole_start);
	endproperty
	a_read_start: assert property (p_read_start) else $error("hole start read wrong");

	property p_tom_write;
		@(posedge clk_i) disable iff (!rst_n)
		cfg_wr_i && cfg_idx_i == frd_pkg::IDX_DECODE_CTRL
			|=> top_of_main_memory == $past(cfg_wdata_i[frd_pkg::TOM_MSB:frd_pkg::TOM_LSB]);
	endproperty
	a_tom_write: assert property (p_tom_write) else $error("top of memory not stored");

	property p_addon_write;
		@(posedge clk_i) disable iff (!rst_n)
		cfg_wr_i && cfg_idx_i == frd_pkg::IDX_ADDON_BIOS |=> s_r.addon_bios == $past(cfg_wdata_i);
	endproperty
	a_addon_write: assert property (p_addon_write) else $error("add-on enables not stored");
endmodule

/* File: rtl/frd_pkg.sv */
// frd_pkg: constants and state type of the isa-to-pci memory forward decoder.
// assumes: used as frd_pkg::name by every frd module except frd_hole_match, never imported.
package frd_pkg;
	// address widths
	localparam int ADDR_W = 32;
	localparam int LOW_W = 20;
	localparam int MB_MSB = 23;
	localparam int MB_LSB = 20;

	// configuration indices
	localparam logic [7:0] IDX_DECODE_CTRL = 8'h48;
	localparam logic [7:0] IDX_ADDON_BIOS = 8'h49;
	localparam logic [7:0] IDX_HOLE_START = 8'h4A;
	localparam logic [7:0] IDX_HOLE_SIZE = 8'h4B;

	// values after reset
	localparam logic [7:0] DECODE_CTRL_RST = 8'h01;
	localparam logic [7:0] ADDON_BIOS_RST = 8'h00;
	localparam logic [7:0] HOLE_START_RST = 8'h00;
	localparam logic [7:0] HOLE_SIZE_RST = 8'h00;
	localparam logic [7:0] RDATA_NONE = 8'h00;

	// forward_decode_control fields
	localparam int TOM_MSB = 7;
	localparam int TOM_LSB = 4;
	localparam int LOW_BIOS_BIT = 3;
	localparam int VIDEO_BIT = 2;
	localparam int B640_BIT = 1;
	localparam int B512_BIT = 0;

	// memory_hole_size_enable fields
	localparam int HOLE_EN_BIT = 7;
	localparam int HOLE_SIZE_MSB = 6;

	// 128 KB segment codes below 1 MB, address bits 19:17
	localparam logic [2:0] SEG_512K = 3'h4;
	localparam logic [2:0] SEG_VIDEO = 3'h5;
	localparam logic [2:0] SEG_ADDON = 3'h6;
	localparam logic [2:0] SEG_BIOS = 3'h7;

	typedef struct packed {
		logic [7:0] decode_ctrl;
		logic [7:0] addon_bios;
		logic [7:0] hole_start;
		logic [7:0] hole_size;
		logic [7:0] rdata;
		logic rvalid;
		logic dvalid;
		logic fwd;
		logic keep;
	} frd_state_t;
endpackage

/* File: rtl/frd_hole_match.sv */
// frd_hole_match: combinational test of an address against the memory hole.
// assumes: inputs all on one clock; caller applies the hole enable.
`timescale 1ns/1ps
module frd_hole_match (
	// address bits 23:16
	input wire logic [7:0] addr_hi_i,
	// hole registers
	input wire logic [7:0] hole_start_address_i,
	input wire logic [6:0] hole_size_code_i,
	// result
	output logic match_o
);
	logic [7:0] cmp_mask;

	always_comb begin
		// each low-order one drops one more compared bit, doubling the size
		cmp_mask = ~{1'b0, hole_size_code_i};
		// compare under the mask against bits 23:16
		match_o = ((addr_hi_i ^ hole_start_address_i) & cmp_mask) == 8'h00;
	end
endmodule

/* File: rtl/frd_low_region.sv */
// frd_low_region: forwarding decision for addresses below 1 MB.
// assumes: caller only trusts hit_o when address bits above 19 are zero.
`timescale 1ns/1ps
module frd_low_region (
	// address below 1 MB
	input wire logic [frd_pkg::LOW_W-1:0] addr_i,
	// enables
	input wire logic [7:0] decode_ctrl_i,
	input wire logic [7:0] addon_bios_i,
	input wire logic lower_bios_select_enable_i,
	// result
	output logic hit_o
);
	always_comb begin
		hit_o = 1'b0;
		if (!addr_i[19]) begin
			hit_o = decode_ctrl_i[frd_pkg::B512_BIT];
		end else begin
			case (addr_i[19:17])
				frd_pkg::SEG_512K: begin
					hit_o = decode_ctrl_i[frd_pkg::B640_BIT];
				end
				frd_pkg::SEG_VIDEO: begin
					hit_o = decode_ctrl_i[frd_pkg::VIDEO_BIT];
				end
				frd_pkg::SEG_ADDON: begin
					// eight 16 KB blocks, bit n at 768+16n KB
					hit_o = addon_bios_i[addr_i[16:14]];
				end
				frd_pkg::SEG_BIOS: begin
					// upper 64 KB belongs to the boot rom, never forwarded
					hit_o = !addr_i[16] && decode_ctrl_i[frd_pkg::LOW_BIOS_BIT]
						&& !lower_bios_select_enable_i;
				end
				default: begin
					hit_o = 1'b0;
				end
			endcase
		end
	end
endmodule

/* File: test/frd_isa_master_model.sv */
// frd_isa_master_model: isa master or dma source issuing memory cycle requests.
// assumes: shares the decoder clock; caller waits for each decision.
`timescale 1ns/1ps
module frd_isa_master_model (
	// clock
	input wire logic clk_i,
	// memory cycle request
	output logic mem_req_o,
	output logic [frd_pkg::ADDR_W-1:0] mem_addr_o
);
	initial begin
		mem_req_o = 1'b0;
		mem_addr_o = 32'h0000_0000;
	end
	// released address shows the inverse, so a stale value never passes as valid
	task automatic issue(input logic [frd_pkg::ADDR_W-1:0] a);
		@(posedge clk_i);
		#1;
		mem_req_o = 1'b1;
		mem_addr_o = a;
		@(posedge clk_i);
		#1;
		mem_req_o = 1'b0;
		mem_addr_o = ~a;
	endtask
endmodule

/* File: test/tb.sv */
// tb: self-checking bench for the memory forward decoder.
// assumes: decision and read data land one cycle after the request edge.
`timescale 1ns/1ps
module tb;
	logic clk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic cfg_wr_i = 1'b0;
	logic cfg_rd_i = 1'b0;
	logic lbse = 1'b0;
	logic [7:0] cfg_idx_i = 8'h00;
	logic [7:0] cfg_wdata_i = 8'h00;
	logic [7:0] cfg_rdata_o;
	logic cfg_rvalid_o, mem_req_i, dec_valid_o, forward_o, keep_isa_o;
	logic [31:0] mem_addr_i;
	logic [7:0] ctrl = 8'h01;
	logic [7:0] addon = 8'h00;
	logic [7:0] hst = 8'h00;
	logic [7:0] hsz = 8'h00;
	logic [31:0] low_addr [9] = '{32'h00000, 32'h7FFFF, 32'h80000, 32'h9FFFF, 32'hA0000,
		32'hBFFFF, 32'hE0000, 32'hEFFFF, 32'hF0000};
	int bad_count = 0;
	int checks_done = 0;

	always #5 clk_i = ~clk_i;

	frd_isa_master_model u_isa (.clk_i(clk_i), .mem_req_o(mem_req_i), .mem_addr_o(mem_addr_i));

	frd_forward_decoder u_dut (
		.clk_i(clk_i), .nrst_i(nrst_i), .cfg_wr_i(cfg_wr_i), .cfg_rd_i(cfg_rd_i),
		.cfg_idx_i(cfg_idx_i), .cfg_wdata_i(cfg_wdata_i), .cfg_rdata_o(cfg_rdata_o),
		.cfg_rvalid_o(cfg_rvalid_o), .lower_bios_select_enable_i(lbse),
		.mem_req_i(mem_req_i), .mem_addr_i(mem_addr_i), .dec_valid_o(dec_valid_o),
		.forward_o(forward_o), .keep_isa_o(keep_isa_o));

	task automatic conclude();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// expected decision from the shadow copies of the registers
	function automatic logic exp_fwd(input logic [31:0] a);
		logic [7:0] m;
		m = ~{1'b0, hsz[6:0]};
		if (a[31:24] != 8'h00) return 1'b1;
		if (hsz[7] && ((a[23:16] ^ hst) & m) == 8'h00) return 1'b0;
		if (a[23:20] != 4'h0) return a[23:20] <= ctrl[7:4];
		if (!a[19]) return ctrl[0];
		case (a[18:17])
			2'h0: return ctrl[1];
			2'h1: return ctrl[2];
			2'h2: return addon[a[16:14]];
			default: return !a[16] && ctrl[3] && !lbse;
		endcase
	endfunction

	function automatic logic [7:0] shadow(input logic [7:0] idx);
		case (idx)
			frd_pkg::IDX_DECODE_CTRL: return ctrl;
			frd_pkg::IDX_ADDON_BIOS: return addon;
			frd_pkg::IDX_HOLE_START: return hst;
			frd_pkg::IDX_HOLE_SIZE: return hsz;
			default: return 8'h00;
		endcase
	endfunction

	task automatic chk_reg(input string name, input logic [7:0] exp, input logic [7:0] got);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic cfg_wr(input logic [7:0] idx, input logic [7:0] d);
		@(posedge clk_i);
		#1;
		cfg_wr_i = 1'b1;
		cfg_idx_i = idx;
		cfg_wdata_i = d;
		@(posedge clk_i);
		#1;
		cfg_wr_i = 1'b0;
		cfg_wdata_i = ~d;
		case (idx)
			frd_pkg::IDX_DECODE_CTRL: ctrl = d;
			frd_pkg::IDX_ADDON_BIOS: addon = d;
			frd_pkg::IDX_HOLE_START: hst = d;
			frd_pkg::IDX_HOLE_SIZE: hsz = d;
			default: ;
		endcase
	endtask

	task automatic cfg_rd_chk(input logic [7:0] idx);
		@(posedge clk_i);
		#1;
		cfg_rd_i = 1'b1;
		cfg_idx_i = idx;
		@(posedge clk_i);
		#1;
		cfg_rd_i = 1'b0;
		cfg_idx_i = ~idx;
		chk_reg("read valid", 8'h01, {7'h00, cfg_rvalid_o});
		chk_reg("read data", shadow(idx), cfg_rdata_o);
	endtask

	task automatic dec_chk(input logic [31:0] a);
		logic e;
		e = exp_fwd(a);
		u_isa.issue(a);
		checks_done++;
		if (dec_valid_o !== 1'b1 || forward_o !== e || keep_isa_o !== !e) begin
			bad_count++;
			$display("BAD decision at %h expected fwd %b seen valid %b fwd %b keep %b",
				a, e, dec_valid_o, forward_o, keep_isa_o);
		end
	endtask

	initial begin
		#500000;
		bad_count++;
		conclude();
	end

	initial begin
		logic [31:0] r;
		logic [7:0] idx;
		void'($urandom(32'h7B8016C7));
		repeat (12) @(posedge clk_i);
		#1;
		nrst_i = 1'b1;
		repeat (3) @(posedge clk_i);
		// reset values, then an unmapped index
		for (int i = 8'h48; i <= 8'h4C; i++) cfg_rd_chk(8'(i));
		dec_chk(32'h4_0000);
		dec_chk(32'h9_0000);
		for (int c = 0; c < 16; c++) begin
			cfg_wr(frd_pkg::IDX_DECODE_CTRL, 8'(c));
			foreach (low_addr[k]) dec_chk(low_addr[k]);
		end
		lbse = 1'b1;
		dec_chk(32'hE8000);
		lbse = 1'b0;
		for (int b = 0; b < 8; b++) begin
			cfg_wr(frd_pkg::IDX_ADDON_BIOS, 8'h01 << b);
			for (int k = 0; k < 8; k++) begin
				dec_chk(32'hC0000 + k * 32'h4000);
				dec_chk(32'hC3FFF + k * 32'h4000);
			end
		end
		for (int n = 0; n < 16; n++) begin
			cfg_wr(frd_pkg::IDX_DECODE_CTRL, 8'(n << 4));
			dec_chk((32'(n) + 1) * 32'h10_0000 - 1);
			dec_chk((32'(n) + 1) * 32'h10_0000);
			dec_chk(32'h100_0000);
		end
		// hole sizes walked with the legal patterns only
		cfg_wr(frd_pkg::IDX_HOLE_START, 8'h40);
		for (int k = 0; k < 8; k++) begin
			cfg_wr(frd_pkg::IDX_HOLE_SIZE, 8'h80 | 8'((1 << k) - 1));
			dec_chk(32'h40_0000);
			dec_chk(32'h40_0000 + (32'h1_0000 << k) - 1);
			dec_chk(32'h40_0000 + (32'h1_0000 << k));
			dec_chk(32'h3F_FFFF);
			dec_chk(32'hFF_FFFF);
		end
		cfg_wr(frd_pkg::IDX_HOLE_SIZE, 8'h00);
		dec_chk(32'h40_0000);
		repeat (300) begin
			r = $urandom;
			idx = 8'h48 + 8'(r[1:0]);
			if (idx == frd_pkg::IDX_HOLE_SIZE)
				cfg_wr(idx, {r[8], 7'((1 << r[12:10]) - 1)});
			else
				cfg_wr(idx, r[23:16]);
			cfg_rd_chk(idx);
			lbse = r[31];
			r = $urandom;
			case (r[1:0])
				2'h0: dec_chk({12'h000, r[31:12]});
				2'h1: dec_chk({8'h00, hst ^ {5'h00, r[4:2]}, r[31:16]});
				2'h2: dec_chk({8'h00, r[31:8]});
				default: dec_chk(r);
			endcase
		end
		conclude();
	end
endmodule
